// *** core/emb_ctrl.sv ***
// Multiplexed external memory bus master: two-phase address/data cycles.
// Assumes the core issues one request at a time and holds it until done.
`timescale 1ns/100ps
`default_nettype none

module emb_ctrl
	import emb_pkg::*;
#(
	parameter bit ROMLESS = 1'b0
)
(
	input  wire logic              mclk,
	input  wire logic              rstn,
	input  wire logic              req_valid,
	output logic                   req_ready,
	input  wire logic              req_write,
	input  wire logic              req_external,
	input  wire logic              block_select_addr_bit,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [DATA_W-1:0] req_wdata,
	output logic                   rsp_valid,
	output logic [DATA_W-1:0]      rsp_rdata,
	input  wire logic              bus_float_bit,
	input  wire logic              wait_enable,
	input  wire logic              bus_request_n_enable,
	input  wire logic              rw_alt_func,
	input  wire logic              lower_strobe_alt_func,
	input  wire logic              lower_strobe_enable,
	input  wire logic              wait_pin_n,
	input  wire logic              bus_request_n,
	output logic                   bus_grant_n,
	output logic                   ext_bus_mode,
	output logic                   addr_strobe_n,
	output logic                   addr_strobe_oe_n,
	output logic                   addr_strobe_pull_up,
	output logic                   data_strobe_n,
	output logic                   data_strobe_oe_n,
	output logic                   lower_block_strobe_n,
	output logic                   lower_block_strobe_oe_n,
	output logic                   rw_n,
	output logic                   rw_oe_n,
	output logic                   strobe_pull_up,
	input  wire logic [7:0]        muxed_addr_data_port_in,
	output logic [7:0]             muxed_addr_data_port_out,
	output logic [7:0]             muxed_addr_data_port_oe_n,
	output logic [7:0]             high_addr_port_out,
	output logic [7:0]             high_addr_port_oe_n
);
	initial begin
		if (ADDR_W != 16 || DATA_W != 8)
			$error("emb_ctrl serves only 16-bit address and 8-bit data");
	end

	emb_sync_if sync ();

	emb_sync u_sync (
		.mclk       (mclk),
		.rstn       (rstn),
		.wait_pin_n (wait_pin_n),
		.req_pin_n  (bus_request_n),
		.sync       (sync)
	);

	emb_state_type state_q;
	emb_state_type state_d;
	logic [7:0]  lo_q;
	logic [7:0]  hi_q;
	logic        write_q;
	logic        ext_q;
	logic        upper_q;
	logic        drive_lo_q;
	logic        rw_q;
	logic        boot_q;
	logic [1:0]  boot_wait_q;
	logic        grant_q;
	logic        floated;
	logic        wait_hold;
	logic        phase_end;
	logic        rd_done;
	logic        in_reset_q;
	logic        grant_take;

	// Extra boot wait cycles stand in for the romless fetch stretching
	assign wait_hold = (wait_enable || boot_q) && !sync.wait_n;
	assign phase_end = !wait_hold && boot_wait_q == WAIT_NONE;
	assign floated   = grant_q || bus_float_bit;

	// Phase sequencer: request in idle, address, data, back
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			EMB_IDLE: begin
				if (grant_q)
					state_d = EMB_FLOAT;
				else if (req_valid && req_ready)
					state_d = EMB_ADDR;
			end
			EMB_ADDR: begin
				if (phase_end)
					state_d = EMB_DATA;
			end
			EMB_DATA: begin
				if (phase_end)
					state_d = EMB_IDLE;
			end
			EMB_FLOAT: begin
				if (!grant_q)
					state_d = EMB_IDLE;
			end
			default: state_d = EMB_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			state_q <= EMB_IDLE;
		else
			state_q <= state_d;
	end

	// A pending bus request wins over a new access so none is torn apart
	assign grant_take = bus_request_n_enable && !sync.req_n && state_q == EMB_IDLE;
	assign req_ready  = state_q == EMB_IDLE && !grant_q && !grant_take;
	assign rd_done   = state_q == EMB_DATA && phase_end && !write_q;

	// Request only taken between cycles so an access is never torn apart
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			grant_q <= 1'b0;
		else if (grant_take)
			grant_q <= 1'b1;
		else if (sync.req_n || !bus_request_n_enable)
			grant_q <= 1'b0;
	end

	// Latch address, direction and block at the start of each cycle
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			lo_q    <= PORT_ALL_OFF;
			hi_q    <= PORT_ALL_OFF;
			write_q <= 1'b0;
			ext_q   <= 1'b0;
			upper_q <= 1'b1;
			rw_q    <= 1'b1;
		end else if (req_ready && req_valid) begin
			lo_q    <= req_addr[LO_W-1:0];
			hi_q    <= req_addr[ADDR_W-1:HI_LSB];
			write_q <= req_write;
			ext_q   <= req_external || boot_q;
			upper_q <= block_select_addr_bit;
			rw_q    <= !req_write;
		end else if (state_q == EMB_ADDR && phase_end && write_q) begin
			lo_q    <= req_wdata;
		end
	end

	// Port 0 drives address, then floats on reads and drives on writes
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			drive_lo_q <= 1'b0;
		else if (state_d == EMB_ADDR)
			drive_lo_q <= 1'b1;
		else if (state_q == EMB_ADDR && phase_end && !write_q)
			drive_lo_q <= 1'b0;
	end

	// Romless part boots externally with the longest wait count
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			boot_q     <= 1'b0;
			in_reset_q <= 1'b1;
		end else begin
			in_reset_q <= 1'b0;
			if (in_reset_q)
				boot_q <= ROMLESS;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			boot_wait_q <= WAIT_NONE;
		else if (state_d != state_q && boot_q)
			boot_wait_q <= BOOT_WAITS;
		else if (boot_wait_q != WAIT_NONE)
			boot_wait_q <= boot_wait_q - 2'h1;
	end

	// Read data captured at the end of data phase; the memory answers the
	// strobes that mclk gates, so the port is in this clock's domain
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rsp_rdata <= 8'h00;
			rsp_valid <= 1'b0;
		end else begin
			rsp_valid <= state_q == EMB_DATA && phase_end;
			if (rd_done)
				rsp_rdata <= muxed_addr_data_port_in;
		end
	end

	// Strobes gated by clock high; a known glitch-prone trade-off of timing
	logic ext_active;
	assign ext_active = ext_q && !floated;
	assign addr_strobe_n = !(state_q == EMB_ADDR && mclk);
	assign data_strobe_n = !(state_q == EMB_DATA && ext_active && mclk
		&& (upper_q || !lower_strobe_enable));
	assign lower_block_strobe_n = !(state_q == EMB_DATA && ext_active && mclk
		&& !upper_q && lower_strobe_enable);
	assign rw_n = rw_q;

	// Output enables are low while the pin is driven
	assign addr_strobe_oe_n        = floated;
	assign data_strobe_oe_n        = floated;
	assign lower_block_strobe_oe_n = floated || !lower_strobe_alt_func;
	assign rw_oe_n                 = floated || !rw_alt_func;
	assign muxed_addr_data_port_out  = lo_q;
	assign muxed_addr_data_port_oe_n = {8{floated || !drive_lo_q || !ext_q}};
	assign high_addr_port_out        = hi_q;
	assign high_addr_port_oe_n       = {8{floated || !ext_q}};
	assign bus_grant_n               = !grant_q;
	assign ext_bus_mode              = boot_q;

	// Weak pull-ups stand during reset so pins read high
	assign addr_strobe_pull_up = !rstn;
	assign strobe_pull_up      = !rstn;

	// Assertions
	sequence s_addr_then_data;
		state_q == EMB_ADDR ##[1:8] state_q == EMB_DATA;
	endsequence

	a_phase_order: assert property (@(posedge mclk) disable iff (!rstn)
		state_q == EMB_IDLE && state_d == EMB_ADDR |=> s_addr_then_data)
		else $error("address phase not followed by data phase");

	a_addr_hold: assert property (@(posedge mclk) disable iff (!rstn)
		state_q == EMB_DATA |-> $stable(hi_q))
		else $error("high address changed in data phase");

	a_read_float: assert property (@(posedge mclk) disable iff (!rstn)
		state_q == EMB_DATA && !write_q |-> muxed_addr_data_port_oe_n == 8'hff)
		else $error("muxed port driven in read data phase");

	a_write_data: assert property (@(posedge mclk) disable iff (!rstn)
		state_q == EMB_ADDR && phase_end && write_q |=> lo_q == $past(req_wdata))
		else $error("write data not placed on muxed port");

	a_int_strobe: assert property (@(negedge mclk) disable iff (!rstn)
		!ext_q |-> data_strobe_n && lower_block_strobe_n)
		else $error("data strobe active on internal access");

	a_float_pins: assert property (@(posedge mclk) disable iff (!rstn)
		bus_float_bit |-> addr_strobe_oe_n && data_strobe_oe_n && rw_oe_n)
		else $error("strobes driven while bus floated");

	a_rw_level: assert property (@(posedge mclk) disable iff (!rstn)
		state_q != EMB_IDLE && state_q != EMB_FLOAT |-> rw_n == !write_q)
		else $error("read/write line wrong for cycle");

	a_rw_alt: assert property (@(posedge mclk) disable iff (!rstn)
		!rw_alt_func |-> rw_oe_n && lower_block_strobe_oe_n == 1'b1
			|| lower_strobe_alt_func)
		else $error("read/write driven without alternate mode");

	a_grant_float: assert property (@(posedge mclk) disable iff (!rstn)
		grant_q |-> state_q != EMB_ADDR && state_q != EMB_DATA
			|| $past(state_q) != EMB_IDLE)
		else $error("access started while bus granted");

	a_wait_stretch: assert property (@(posedge mclk) disable iff (!rstn)
		state_q == EMB_ADDR && wait_hold |=> state_q == EMB_ADDR)
		else $error("wait sample did not stretch address phase");
endmodule

`default_nettype wire

// *** core/emb_pkg.sv ***
// Constants and types shared by the external memory bus interface.
// Assumes a single 20 MHz system clock and an active-low async reset.
package emb_pkg;

	localparam int ADDR_W       = 16;
	localparam int DATA_W       = 8;
	localparam int LO_W         = 8;
	localparam int HI_LSB       = 8;
	localparam int WAIT_CNT_W   = 2;
	localparam logic [1:0] WAIT_NONE = 2'h0;
	localparam logic [1:0] BOOT_WAITS = 2'h3;
	localparam logic [7:0] PORT_ALL_OFF = 8'hff;

	typedef enum logic [2:0] {
		EMB_IDLE  = 3'h0,
		EMB_ADDR  = 3'h1,
		EMB_DATA  = 3'h2,
		EMB_FLOAT = 3'h3
	} emb_state_type;

endpackage

// *** core/emb_sync.sv ***
// Two-flop synchroniser for the asynchronous pin inputs of the bus.
// Assumes the pins are raw board inputs with no relation to mclk.
`timescale 1ns/100ps
`default_nettype none

module emb_sync
	import emb_pkg::*;
(
	input  wire logic         mclk,
	input  wire logic         rstn,
	input  wire logic         wait_pin_n,
	input  wire logic         req_pin_n,
	emb_sync_if.src           sync
);
	logic [1:0] meta_q;
	logic [1:0] stable_q;

	// First stage is read only by the second; idle level is high
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			meta_q   <= 2'h3;
			stable_q <= 2'h3;
		end else begin
			meta_q   <= {wait_pin_n, req_pin_n};
			stable_q <= meta_q;
		end
	end

	assign sync.wait_n = stable_q[1];
	assign sync.req_n  = stable_q[0];
endmodule

`default_nettype wire

// *** core/emb_sync_if.sv ***
// Interface between the bus controller and its pin input synchroniser.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
`default_nettype none

interface emb_sync_if;
	logic       wait_n;
	logic       req_n;

	modport src (output wait_n, output req_n);
	modport dst (input wait_n, input req_n);
endinterface

`default_nettype wire

// *** testbench/emb_mem_model.sv ***
// Behavioural external memory on the multiplexed bus, 256 bytes deep.
// Assumes the bus master drives the strobes as active-low pulses.
`timescale 1ns/100ps
`default_nettype none

module emb_mem_model (
	input  wire logic       mclk,
	input  wire logic       addr_strobe_n,
	input  wire logic       data_strobe_n,
	input  wire logic       lower_block_strobe_n,
	input  wire logic       rw_n,
	input  wire logic [7:0] lo_port,
	input  wire logic [7:0] hi_port,
	output logic      [7:0] data_pin
);
	logic [7:0]  mem [0:255];
	logic [15:0] addr_q;
	logic [7:0]  rd_q;
	int          hold;
	wire         sel_n = data_strobe_n & lower_block_strobe_n;

	// Strobes looked at inside the clock-high half, so delta glitches
	// at phase boundaries cannot latch a wrong address
	always @(posedge mclk) begin
		if (hold > 0)
			hold = hold - 1;
		#5;
		if (addr_strobe_n === 1'b0)
			addr_q = {hi_port, lo_port};
		if (sel_n === 1'b0) begin
			if (rw_n === 1'b0)
				mem[addr_q[7:0]] = lo_port;
			else begin
				rd_q = mem[addr_q[7:0]];
				hold = 3;
			end
		end
	end
	// Released bus shows the inverse so a late sample cannot pass by luck
	assign data_pin = (hold > 0) ? rd_q : ~rd_q;
endmodule

`default_nettype wire

// *** testbench/tb_ext_memory_bus_interface.sv ***
// Self-checking bench for the external memory bus controller.
// Assumes the memory model above stands on the multiplexed port.
`timescale 1ns/100ps
`default_nettype none

module tb_ext_memory_bus_interface;
	import emb_pkg::*;
	logic        mclk = 1'b0, rstn = 1'b0, req_valid = 1'b0, req_write = 1'b0;
	logic        req_external = 1'b1, blk = 1'b1, fl = 1'b0, wen = 1'b0;
	logic        ben = 1'b0, rw_af = 1'b1, ls_af = 1'b1, ls_en = 1'b0;
	logic        wait_n = 1'b1, bus_request_n_n = 1'b1;
	logic [15:0] req_addr = 16'h0000;
	logic [7:0]  req_wdata = 8'h00;
	wire logic   req_ready, rsp_valid, grant_n, as_n, as_oe, ds_n, ds_oe;
	wire logic   ls_n, ls_oe, rw_n, rw_oe, as_pu, pu;
	wire logic [7:0] rdata, din, lo_out, hi_out, hi_oe;
	int          failures = 0, cmp_count = 0, ds_cnt, ls_cnt, lat;
	logic        rw_seen;

	always #25 mclk = ~mclk;
	// Strobes counted mid clock-high, immune to zero-time glitches
	always @(posedge mclk) begin
		#12;
		if (ds_n === 1'b0)
			ds_cnt++;
		if (ls_n === 1'b0)
			ls_cnt++;
	end

	emb_ctrl emb_ctrl_i (.mclk(mclk), .rstn(rstn), .req_valid(req_valid),
		.req_ready(req_ready), .req_write(req_write),
		.req_external(req_external), .block_select_addr_bit(blk),
		.req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
		.rsp_rdata(rdata), .bus_float_bit(fl), .wait_enable(wen),
		.bus_request_n_enable(ben), .rw_alt_func(rw_af),
		.lower_strobe_alt_func(ls_af), .lower_strobe_enable(ls_en),
		.wait_pin_n(wait_n), .bus_request_n(bus_request_n_n), .bus_grant_n(grant_n),
		.ext_bus_mode(), .addr_strobe_n(as_n), .addr_strobe_oe_n(as_oe),
		.addr_strobe_pull_up(as_pu), .data_strobe_n(ds_n),
		.data_strobe_oe_n(ds_oe), .lower_block_strobe_n(ls_n),
		.lower_block_strobe_oe_n(ls_oe), .rw_n(rw_n), .rw_oe_n(rw_oe),
		.strobe_pull_up(pu), .muxed_addr_data_port_in(din),
		.muxed_addr_data_port_out(lo_out), .muxed_addr_data_port_oe_n(),
		.high_addr_port_out(hi_out), .high_addr_port_oe_n(hi_oe));

	emb_mem_model emb_mem_model_i (.mclk(mclk), .addr_strobe_n(as_n),
		.data_strobe_n(ds_n), .lower_block_strobe_n(ls_n), .rw_n(rw_n),
		.lo_port(lo_out), .hi_port(hi_out), .data_pin(din));

	// Compare one value, counting every call
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// One bus access; request held until taken, latency counted to rsp_valid
	task automatic acc(input logic w, ext, b, input logic [15:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		@(negedge mclk);
		ds_cnt = 0;
		ls_cnt = 0;
		{req_valid, req_write, req_external, blk} = {1'b1, w, ext, b};
		req_addr = a;
		req_wdata = d;
		while (req_ready !== 1'b1 && n < 50) begin
			@(negedge mclk);
			n++;
		end
		@(posedge mclk);
		lat = 0;
		@(negedge mclk);
		req_valid = 1'b0;
		rw_seen = rw_n;
		while (rsp_valid !== 1'b1 && lat < 40) begin
			@(posedge mclk);
			#1 lat++;
		end
	endtask

	task automatic t_reset;
		chk({as_n, ds_n, ls_n, rw_n, as_pu, pu}, 16'h003f);
		$display("reset test done");
	endtask

	task automatic t_write_read;
		acc(1'b1, 1'b1, 1'b1, 16'h12a5, 8'h3c);
		chk(lat, 16'h0002);
		chk(rw_seen, 16'h0000);
		chk(ds_cnt, 16'h0001);
		chk(emb_mem_model_i.addr_q, 16'h12a5);
		chk(emb_mem_model_i.mem[8'ha5], 16'h003c);
		acc(1'b0, 1'b1, 1'b1, 16'h12a5, 8'h00);
		chk(lat, 16'h0002);
		chk(rw_seen, 16'h0001);
		chk(rdata, 16'h003c);
		$display("write and read test done");
	endtask

	task automatic t_lower;
		ls_en = 1'b1;
		acc(1'b0, 1'b1, 1'b0, 16'h12a5, 8'h00);
		chk({ds_cnt[7:0], ls_cnt[7:0]}, 16'h0001);
		chk(rdata, 16'h003c);
		ls_en = 1'b0;
		$display("lower block test done");
	endtask

	task automatic t_internal;
		acc(1'b0, 1'b0, 1'b1, 16'h0040, 8'h00);
		chk(ds_cnt + ls_cnt, 16'h0000);
		chk(lat, 16'h0002);
		$display("internal test done");
	endtask

	task automatic t_wait;
		@(negedge mclk);
		wen = 1'b1;
		wait_n = 1'b0;
		fork
			acc(1'b0, 1'b1, 1'b1, 16'h12a5, 8'h00);
			begin
				repeat (4) @(negedge mclk);
				wait_n = 1'b1;
			end
		join
		chk(lat > 3 && lat < 9, 16'h0001);
		chk(rdata, 16'h003c);
		wen = 1'b0;
		$display("wait test done");
	endtask

	task automatic t_float;
		@(negedge mclk);
		fl = 1'b1;
		rw_af = 1'b0;
		repeat (2) @(negedge mclk);
		chk({as_oe, ds_oe, ls_oe, rw_oe}, 16'h000f);
		fl = 1'b0;
		repeat (2) @(negedge mclk);
		chk(rw_oe, 16'h0001);
		rw_af = 1'b1;
		$display("float test done");
	endtask

	task automatic t_grant;
		@(negedge mclk);
		ben = 1'b1;
		bus_request_n_n = 1'b0;
		repeat (6) @(negedge mclk);
		chk({grant_n, req_ready, as_oe, hi_oe}, 16'h01ff);
		bus_request_n_n = 1'b1;
		repeat (6) @(negedge mclk);
		chk({grant_n, req_ready}, 16'h0003);
		ben = 1'b0;
		$display("grant test done");
	endtask

	// Main sequence: reset then each scenario in turn
	initial begin
		repeat (20) @(posedge mclk);
		t_reset;
		@(negedge mclk);
		rstn = 1'b1;
		t_write_read;
		t_lower;
		t_internal;
		t_wait;
		t_float;
		t_grant;
		wrap_up;
	end

	// Watchdog: the whole run needs well under a thousand cycles
	initial begin
		#(5000 * 50);
		failures++;
		wrap_up;
	end
endmodule

`default_nettype wire
